// ==== logic/timer16_defs.vh ====
// Constants for the 16-bit timer slice: register map, fields, reset values
`ifndef TIMER16_DEFS_VH
`define TIMER16_DEFS_VH

// ----------------------------------------------------------------------
// Register addresses (4-bit I/O space, slice-local)
// ----------------------------------------------------------------------
`define ADR_CNT_LO 4'h0
`define ADR_CNT_HI 4'h1
`define ADR_CMPA_LO 4'h2
`define ADR_CMPA_HI 4'h3
`define ADR_CMPB_LO 4'h4
`define ADR_CMPB_HI 4'h5
`define ADR_CAP_LO 4'h6
`define ADR_CAP_HI 4'h7
`define ADR_CTRL_A 4'h8
`define ADR_CTRL_B 4'h9
`define ADR_FLAGS 4'hA
`define ADR_IRQ_EN 4'hB

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTLA_WGM_LO 1:0
`define CTLB_CS 2:0
`define CTLB_WGM_HI 4:3
`define CTLB_EDGE 6
`define CTLB_NFE 7
`define FLG_OVF 0
`define FLG_CAP 1
`define IEN_OVF 0
`define IEN_CAP 1

// ----------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------
`define BYTE_ZERO 8'h00
`define WORD_ZERO 16'h0000
`define WORD_ONE 16'h0001
`define WORD_MAX 16'hFFFF
`define TOP_8BIT 16'h00FF
`define TOP_9BIT 16'h01FF
`define TOP_10BIT 16'h03FF
`define CS_STOP 3'h0
`define FILT_LEN 4
`define FILT_ALL 4'hF
`define FILT_NONE 4'h0
`define FILT_HIST_ZERO 3'h0

// Waveform modes that pick a ceiling source or a dual-slope sequence
`define WGM_PC8 4'h1
`define WGM_PC9 4'h2
`define WGM_PC10 4'h3
`define WGM_CTC_A 4'h4
`define WGM_F8 4'h5
`define WGM_F9 4'h6
`define WGM_F10 4'h7
`define WGM_PFC_CAP 4'h8
`define WGM_PFC_A 4'h9
`define WGM_PC_CAP 4'hA
`define WGM_PC_A 4'hB
`define WGM_CTC_CAP 4'hC
`define WGM_F_CAP 4'hE
`define WGM_F_A 4'hF

`endif

// ==== logic/timer16_counter_capture.v ====
// 16-bit timer slice: byte-wide register access, counter core, input capture
// Functional notes
// - One shared 8-bit high-byte holding register
// - Low-byte write loads whole word in one cycle
// - Low-byte read copies high byte to holding
// - Compare reads bypass the holding register
// - Holding register keeps value after low write
// - Counter high location maps to holding register
// - Clock select zero stops the counter
// - Counter accessible with or without tick
// - CPU counter write beats clear or count
// - Tick clears, increments or decrements counter
// - Floor at zero, ceiling at sequence top
// - Mode field sets sequence and overflow condition
// - Matching edge copies counter into capture
// - Capture flag set with copy; enable gates request
// - Flag clears on service or written one
// - Capture writable only in ceiling modes
// - Floor 0x0000, maximum 0xFFFF
// - Filter needs four equal samples
// - Select bit routes comparator to capture
// - Capture input disabled in ceiling modes
`timescale 1ns/100ps
`include "timer16_defs.vh"

module timer16_counter_capture (
  input wire mclk,
  input wire rstn,
  input wire [3:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  input wire tick_in,
  input wire capture_input_pin,
  input wire comparator_output,
  input wire comparator_capture_select,
  input wire capture_irq_ack,
  input wire overflow_irq_ack,
  output wire capture_irq,
  output wire overflow_irq,
  output wire count_floor,
  output wire count_ceiling,
  output wire [3:0] waveform_mode_field,
  output wire [15:0] compare_a_value,
  output wire [15:0] compare_b_value
);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg [7:0] hold_ff;
  reg [15:0] counter_value_ff;
  reg [15:0] capture_value_ff;
  reg [15:0] cmpa_ff;
  reg [15:0] cmpb_ff;
  reg [7:0] control_reg_a_ff;
  reg [7:0] control_reg_b_ff;
  reg down_ff;
  reg overflow_flag_ff;
  reg capture_flag_ff;
  reg [1:0] irq_en_ff;
  reg [2:0] src_sync_ff;
  reg src_stable_ff;
  reg [2:0] filt_hist_ff;
  reg filt_out_ff;
  reg edge_prev_ff;

  wire [3:0] wgm;
  wire cap_is_top;
  wire dual_slope;
  wire tick;
  wire [15:0] top_val;
  wire wr_cnt_lo;
  wire wr_cap_lo;
  wire wrap_max;
  wire [3:0] filt_window;

  // Decoded bus strobes
  wire wr_hold;
  wire rd_cnt_lo;
  wire rd_cap_lo;
  wire wr_cmpa_lo;
  wire wr_cmpb_lo;
  wire wr_ctrl_a;
  wire wr_ctrl_b;
  wire wr_irq_en;
  wire wr_flags;
  wire clr_cap;
  wire clr_ovf;
  wire src_raw;
  wire filt_in;
  wire edge_in;
  wire cap_event;
  reg [15:0] nxt_counter;
  reg nxt_down;
  reg ovf_evt;
  reg [7:0] nxt_rdata;

  assign wgm = {control_reg_b_ff[`CTLB_WGM_HI], control_reg_a_ff[`CTLA_WGM_LO]};
  assign waveform_mode_field = wgm;
  assign compare_a_value = cmpa_ff;
  assign compare_b_value = cmpb_ff;

  // Modes where the capture register defines the ceiling
  assign cap_is_top = (wgm == `WGM_PFC_CAP) || (wgm == `WGM_PC_CAP) ||
                      (wgm == `WGM_CTC_CAP) || (wgm == `WGM_F_CAP);
  assign dual_slope = (wgm == `WGM_PC8) || (wgm == `WGM_PC9) || (wgm == `WGM_PC10) ||
                      (wgm == `WGM_PFC_CAP) || (wgm == `WGM_PFC_A) ||
                      (wgm == `WGM_PC_CAP) || (wgm == `WGM_PC_A);

  // --------------------------------------------------------------------
  // Ceiling selection
  // --------------------------------------------------------------------
  assign top_val = (wgm == `WGM_PC8 || wgm == `WGM_F8) ? `TOP_8BIT :
                   (wgm == `WGM_PC9 || wgm == `WGM_F9) ? `TOP_9BIT :
                   (wgm == `WGM_PC10 || wgm == `WGM_F10) ? `TOP_10BIT :
                   (wgm == `WGM_CTC_A || wgm == `WGM_PFC_A ||
                    wgm == `WGM_PC_A || wgm == `WGM_F_A) ? cmpa_ff :
                   cap_is_top ? capture_value_ff : `WORD_MAX;

  assign count_floor = (counter_value_ff == `WORD_ZERO);
  assign count_ceiling = (counter_value_ff == top_val);

  // A counter written above its ceiling runs on to MAX and wraps there
  assign wrap_max = (counter_value_ff == `WORD_MAX);

  // Tick comes from the prescaler on this clock; select zero gates it off
  assign tick = tick_in && (control_reg_b_ff[`CTLB_CS] != `CS_STOP);

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  assign wr_cnt_lo = io_wr && (io_addr == `ADR_CNT_LO);
  assign wr_cap_lo = io_wr && (io_addr == `ADR_CAP_LO) && cap_is_top;
  // Every high-location write goes to the shared holding byte, whatever the mode
  assign wr_hold = io_wr && ((io_addr == `ADR_CNT_HI) || (io_addr == `ADR_CMPA_HI) ||
                             (io_addr == `ADR_CMPB_HI) || (io_addr == `ADR_CAP_HI));
  assign rd_cnt_lo = io_rd && (io_addr == `ADR_CNT_LO);
  assign rd_cap_lo = io_rd && (io_addr == `ADR_CAP_LO);
  assign wr_cmpa_lo = io_wr && (io_addr == `ADR_CMPA_LO);
  assign wr_cmpb_lo = io_wr && (io_addr == `ADR_CMPB_LO);
  assign wr_ctrl_a = io_wr && (io_addr == `ADR_CTRL_A);
  assign wr_ctrl_b = io_wr && (io_addr == `ADR_CTRL_B);
  assign wr_irq_en = io_wr && (io_addr == `ADR_IRQ_EN);
  assign wr_flags = io_wr && (io_addr == `ADR_FLAGS);
  // Service acknowledge and a written one clear alike
  assign clr_cap = capture_irq_ack || (wr_flags && io_wdata[`FLG_CAP]);
  assign clr_ovf = overflow_irq_ack || (wr_flags && io_wdata[`FLG_OVF]);

  // --------------------------------------------------------------------
  // Counter next state
  // --------------------------------------------------------------------
  always @* begin
    nxt_counter = counter_value_ff;
    nxt_down = down_ff;
    ovf_evt = 1'b0;
    if (tick) begin
      if (dual_slope) begin
        if (!down_ff && count_ceiling) begin
          nxt_down = 1'b1;
          nxt_counter = counter_value_ff - `WORD_ONE;
        end else if (down_ff && count_floor) begin
          nxt_down = 1'b0;
          nxt_counter = counter_value_ff + `WORD_ONE;
          ovf_evt = 1'b1;
        end else if (down_ff) begin
          nxt_counter = counter_value_ff - `WORD_ONE;
        end else begin
          nxt_counter = counter_value_ff + `WORD_ONE;
        end
      end else begin
        nxt_down = 1'b0;
        if (count_ceiling) begin
          nxt_counter = `WORD_ZERO;
          // Clear-on-match modes flag at MAX only; others at their ceiling
          ovf_evt = ((wgm == `WGM_CTC_A) || (wgm == `WGM_CTC_CAP)) ?
                    wrap_max : 1'b1;
        end else begin
          nxt_counter = counter_value_ff + `WORD_ONE;
          ovf_evt = wrap_max;
        end
      end
    end
    if (wr_cnt_lo) begin
      nxt_counter = {hold_ff, io_wdata};
    end
  end

  // --------------------------------------------------------------------
  // Capture path: 3-stage sync, optional filter, edge detect
  // --------------------------------------------------------------------
  assign src_raw = comparator_capture_select ? comparator_output : capture_input_pin;
  assign filt_in = src_stable_ff;
  // Three held samples plus the present one: four equal samples move the output
  assign filt_window = {filt_hist_ff, filt_in};
  assign edge_in = control_reg_b_ff[`CTLB_NFE] ? filt_out_ff : src_stable_ff;
  // Edge compare against last stable level; ceiling modes shut it off
  assign cap_event = !cap_is_top && (edge_in != edge_prev_ff) &&
                     (edge_in == control_reg_b_ff[`CTLB_EDGE]);

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      src_sync_ff <= 3'h0;
      src_stable_ff <= 1'b0;
      filt_hist_ff <= `FILT_HIST_ZERO;
      filt_out_ff <= 1'b0;
      edge_prev_ff <= 1'b0;
    end else begin
      src_sync_ff <= {src_sync_ff[1:0], src_raw};
      // Level accepted only when second and third stages agree
      if (src_sync_ff[1] == src_sync_ff[2]) begin
        src_stable_ff <= src_sync_ff[2];
      end
      filt_hist_ff <= {filt_hist_ff[1:0], filt_in};
      if (filt_window == `FILT_ALL) begin
        filt_out_ff <= 1'b1;
      end else if (filt_window == `FILT_NONE) begin
        filt_out_ff <= 1'b0;
      end
      if (!cap_is_top) begin
        edge_prev_ff <= edge_in;
      end
    end
  end

  // --------------------------------------------------------------------
  // Register file and counter update
  // --------------------------------------------------------------------
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hold_ff <= `BYTE_ZERO;
      counter_value_ff <= `WORD_ZERO;
      capture_value_ff <= `WORD_ZERO;
      cmpa_ff <= `WORD_ZERO;
      cmpb_ff <= `WORD_ZERO;
      down_ff <= 1'b0;
    end else begin
      counter_value_ff <= nxt_counter;
      down_ff <= nxt_down;
      // Holding register: only high-byte writes and low-byte reads touch it
      if (wr_hold) begin
        hold_ff <= io_wdata;
      end else if (rd_cnt_lo) begin
        hold_ff <= counter_value_ff[15:8];
      end else if (rd_cap_lo) begin
        hold_ff <= capture_value_ff[15:8];
      end
      if (wr_cmpa_lo) begin
        cmpa_ff <= {hold_ff, io_wdata};
      end
      if (wr_cmpb_lo) begin
        cmpb_ff <= {hold_ff, io_wdata};
      end
      if (wr_cap_lo) begin
        capture_value_ff <= {hold_ff, io_wdata};
      end else if (cap_event) begin
        capture_value_ff <= counter_value_ff;
      end
    end
  end

  // --------------------------------------------------------------------
  // Control and enable registers
  // --------------------------------------------------------------------
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      control_reg_a_ff <= `BYTE_ZERO;
      control_reg_b_ff <= `BYTE_ZERO;
      irq_en_ff <= 2'h0;
    end else begin
      if (wr_ctrl_a) begin
        control_reg_a_ff <= io_wdata;
      end
      if (wr_ctrl_b) begin
        control_reg_b_ff <= io_wdata;
      end
      if (wr_irq_en) begin
        irq_en_ff <= {io_wdata[`IEN_CAP], io_wdata[`IEN_OVF]};
      end
    end
  end

  // --------------------------------------------------------------------
  // Event flags
  // --------------------------------------------------------------------
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      overflow_flag_ff <= 1'b0;
      capture_flag_ff <= 1'b0;
    end else begin
      // Hardware set wins over a coincident clear, so no event is lost
      if (cap_event) begin
        capture_flag_ff <= 1'b1;
      end else if (clr_cap) begin
        capture_flag_ff <= 1'b0;
      end
      // A counter write discards the count step, and its overflow with it
      if (ovf_evt && !wr_cnt_lo) begin
        overflow_flag_ff <= 1'b1;
      end else if (clr_ovf) begin
        overflow_flag_ff <= 1'b0;
      end
    end
  end

  assign capture_irq = capture_flag_ff && irq_en_ff[`IEN_CAP];
  assign overflow_irq = overflow_flag_ff && irq_en_ff[`IEN_OVF];

  // --------------------------------------------------------------------
  // Read data (registered, valid the cycle after io_rd)
  // --------------------------------------------------------------------
  always @* begin
    case (io_addr)
      `ADR_CNT_LO: nxt_rdata = counter_value_ff[7:0];
      `ADR_CNT_HI: nxt_rdata = hold_ff;
      `ADR_CMPA_LO: nxt_rdata = cmpa_ff[7:0];
      `ADR_CMPA_HI: nxt_rdata = cmpa_ff[15:8];
      `ADR_CMPB_LO: nxt_rdata = cmpb_ff[7:0];
      `ADR_CMPB_HI: nxt_rdata = cmpb_ff[15:8];
      `ADR_CAP_LO: nxt_rdata = capture_value_ff[7:0];
      `ADR_CAP_HI: nxt_rdata = hold_ff;
      `ADR_CTRL_A: nxt_rdata = control_reg_a_ff;
      `ADR_CTRL_B: nxt_rdata = control_reg_b_ff;
      `ADR_FLAGS: nxt_rdata = {6'h00, capture_flag_ff, overflow_flag_ff};
      `ADR_IRQ_EN: nxt_rdata = {6'h00, irq_en_ff};
      default: nxt_rdata = `BYTE_ZERO;
    endcase
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      io_rdata <= `BYTE_ZERO;
    end else if (io_rd) begin
      io_rdata <= nxt_rdata;
    end
  end

endmodule // timer16_counter_capture

// ==== tb/cpu_bus_model.sv ====
// Processor-side byte bus model for the timer slice
`timescale 1ns/100ps
module cpu_bus_model (
  input wire logic mclk,
  output logic [3:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  initial begin
    io_addr = 4'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge mclk);
    io_wr <= 1'b0;
    // Released bus must not keep showing the last byte
    io_wdata <= ~d;
  endtask
  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge mclk);
    io_rd <= 1'b0;
    @(posedge mclk);
    d = io_rdata;
  endtask
  // Whole two-byte sequences only, so nothing can reuse the holding byte in between
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr8(lo + 4'h1, v[15:8]);
    wr8(lo, v[7:0]);
  endtask
  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    rd8(lo, v[7:0]);
    rd8(lo + 4'h1, v[15:8]);
  endtask
endmodule // cpu_bus_model

// ==== tb/timer16_counter_capture_asserts.sv ====
// Port-level checker for the timer slice
`timescale 1ns/100ps
`include "timer16_defs.vh"
module timer16_counter_capture_checker (
  input wire mclk,
  input wire rstn,
  input wire [3:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  input wire [7:0] io_rdata,
  input wire capture_irq_ack,
  input wire capture_irq,
  input wire count_ceiling,
  input wire [3:0] waveform_mode_field,
  input wire [15:0] compare_a_value,
  input wire [15:0] compare_b_value
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  cmpa_word_load_a: assert property (
    io_wr && io_addr == `ADR_CMPA_HI ##2 io_wr && io_addr == `ADR_CMPA_LO |=>
    compare_a_value == {$past(io_wdata, 3), $past(io_wdata)}) else $error("cmpA word");
  cmpb_low_load_a: assert property (
    io_wr && io_addr == `ADR_CMPB_LO |=> compare_b_value[7:0] == $past(io_wdata))
    else $error("cmpB low");
  high_only_hold_a: assert property (
    io_wr && io_addr[0] && io_addr < `ADR_CTRL_A |=> $stable(compare_a_value)
    && $stable(compare_b_value)) else $error("high write reached target");
  cmp_read_direct_a: assert property (
    io_rd && io_addr == `ADR_CMPA_HI |=> io_rdata == $past(compare_a_value[15:8]))
    else $error("cmpA high read");
  mode_low_bits_a: assert property (
    io_wr && io_addr == `ADR_CTRL_A |=> waveform_mode_field[1:0] == $past(io_wdata[1:0]))
    else $error("mode low");
  mode_high_bits_a: assert property (
    io_wr && io_addr == `ADR_CTRL_B |=> waveform_mode_field[3:2] == $past(io_wdata[4:3]))
    else $error("mode high");
  read_data_holds_a: assert property (!io_rd |=> $stable(io_rdata))
    else $error("read data moved");
  cap_flag_clear_a: assert property ($fell(capture_irq) |-> $past(capture_irq_ack)
    || $past(io_wr && (io_addr == `ADR_FLAGS || io_addr == `ADR_IRQ_EN)))
    else $error("capture request dropped");
  cover property (io_wr && io_addr == `ADR_CNT_LO);
  cover property ($rose(capture_irq));
  cover property ($rose(count_ceiling));
endmodule // timer16_counter_capture_checker
bind timer16_counter_capture timer16_counter_capture_checker chk_inst (.mclk, .rstn,
  .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .capture_irq_ack, .capture_irq,
  .count_ceiling, .waveform_mode_field, .compare_a_value, .compare_b_value);

// ==== tb/test_timer16_counter_capture_access.sv ====
// Self-checking bench for the timer slice
`timescale 1ns/100ps
`include "timer16_defs.vh"
module test_timer16_counter_capture_access;
  logic mclk, rstn, tick_in, capture_input_pin, comparator_output;
  logic comparator_capture_select, capture_irq_ack, overflow_irq_ack;
  logic [3:0] io_addr, waveform_mode_field;
  logic io_wr, io_rd, capture_irq, overflow_irq, count_floor, count_ceiling;
  logic [7:0] io_wdata, io_rdata, b;
  logic [15:0] compare_a_value, compare_b_value, w;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  timer16_counter_capture timer16_counter_capture_inst (.mclk, .rstn, .io_addr, .io_wr,
    .io_rd, .io_wdata, .io_rdata, .tick_in, .capture_input_pin, .comparator_output,
    .comparator_capture_select, .capture_irq_ack, .overflow_irq_ack, .capture_irq,
    .overflow_irq, .count_floor, .count_ceiling, .waveform_mode_field, .compare_a_value,
    .compare_b_value);
  cpu_bus_model cpu (.mclk, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata);
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic rw(input logic [3:0] a, input logic [15:0] e);
    cpu.rd16(a, w);
    chk(w, e);
  endtask
  task automatic rb(input logic [3:0] a, input logic [7:0] e);
    cpu.rd8(a, b);
    chk(b, e);
  endtask
  task automatic tk;
    @(posedge mclk);
    tick_in <= 1'b1;
    @(posedge mclk);
    tick_in <= 1'b0;
  endtask
  // Sync plus filter take under ten cycles, thirty leaves margin
  task automatic wirq(input logic e);
    repeat (30) @(posedge mclk);
    chk(capture_irq, e);
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      end_sim;
    end
  end
  // ----------------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------------
  initial begin
    {rstn, tick_in, capture_input_pin, comparator_output} = 4'h0;
    {comparator_capture_select, capture_irq_ack, overflow_irq_ack} = 3'h0;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    chk(count_floor, 1'b1);
    for (int a = 0; a < 16; a++) begin
      rb(a[3:0], 8'h00);
    end
    cpu.wr16(`ADR_CNT_LO, 16'h01FF);
    rw(`ADR_CNT_LO, 16'h01FF);
    cpu.wr8(`ADR_CMPA_HI, 8'h12);
    cpu.wr8(`ADR_CMPA_LO, 8'h34);
    cpu.wr8(`ADR_CMPB_LO, 8'h56);
    @(posedge mclk);
    chk(compare_a_value, 16'h1234);
    chk(compare_b_value, 16'h1256);
    rb(`ADR_CNT_LO, 8'hFF);
    rb(`ADR_CMPA_HI, 8'h12);
    rb(`ADR_CNT_HI, 8'h01);
    tk;
    rw(`ADR_CNT_LO, 16'h01FF);
    cpu.wr8(`ADR_CTRL_B, 8'h01);
    repeat (3) tk;
    rw(`ADR_CNT_LO, 16'h0202);
    cpu.wr8(`ADR_CTRL_B, 8'h09);
    cpu.wr16(`ADR_CNT_LO, 16'h1234);
    tk;
    rw(`ADR_CNT_LO, 16'h0000);
    chk(count_floor, 1'b1);
    cpu.wr8(`ADR_CTRL_B, 8'h01);
    @(posedge mclk);
    tick_in <= 1'b1;
    cpu.wr16(`ADR_CNT_LO, 16'h0500);
    tick_in <= 1'b0;
    rw(`ADR_CNT_LO, 16'h0500);
    cpu.wr8(`ADR_IRQ_EN, 8'h03);
    cpu.wr16(`ADR_CNT_LO, 16'hFFFF);
    @(posedge mclk);
    chk(count_ceiling, 1'b1);
    tk;
    @(posedge mclk);
    chk(overflow_irq, 1'b1);
    overflow_irq_ack <= 1'b1;
    @(posedge mclk);
    overflow_irq_ack <= 1'b0;
    @(posedge mclk);
    chk(overflow_irq, 1'b0);
    cpu.wr8(`ADR_CTRL_B, 8'h09);
    cpu.wr16(`ADR_CNT_LO, 16'hFFFF);
    tk;
    @(posedge mclk);
    chk(overflow_irq, 1'b1);
    cpu.wr8(`ADR_FLAGS, 8'h01);
    @(posedge mclk);
    chk(overflow_irq, 1'b0);
    cpu.wr8(`ADR_CTRL_A, 8'h01);
    cpu.wr8(`ADR_CTRL_B, 8'h01);
    cpu.wr16(`ADR_CNT_LO, 16'h00FF);
    tk;
    rw(`ADR_CNT_LO, 16'h00FE);
    cpu.wr16(`ADR_CNT_LO, 16'h0001);
    repeat (2) tk;
    rw(`ADR_CNT_LO, 16'h0001);
    chk(overflow_irq, 1'b1);
    cpu.wr8(`ADR_FLAGS, 8'h01);
    cpu.wr8(`ADR_CTRL_A, 8'h00);
    cpu.wr16(`ADR_CNT_LO, 16'h0333);
    cpu.wr8(`ADR_CTRL_B, 8'h40);
    capture_input_pin <= 1'b1;
    wirq(1'b1);
    rw(`ADR_CAP_LO, 16'h0333);
    @(posedge mclk);
    capture_irq_ack <= 1'b1;
    @(posedge mclk);
    capture_irq_ack <= 1'b0;
    capture_input_pin <= 1'b0;
    wirq(1'b0);
    cpu.wr8(`ADR_CTRL_B, 8'h00);
    capture_input_pin <= 1'b1;
    wirq(1'b0);
    capture_input_pin <= 1'b0;
    wirq(1'b1);
    cpu.wr8(`ADR_FLAGS, 8'h02);
    wirq(1'b0);
    cpu.wr8(`ADR_CTRL_B, 8'h40);
    comparator_capture_select <= 1'b1;
    cpu.wr16(`ADR_CNT_LO, 16'h0444);
    cpu.wr8(`ADR_FLAGS, 8'h02);
    capture_input_pin <= 1'b1;
    wirq(1'b0);
    comparator_output <= 1'b1;
    wirq(1'b1);
    rw(`ADR_CAP_LO, 16'h0444);
    cpu.wr8(`ADR_FLAGS, 8'h02);
    cpu.wr16(`ADR_CAP_LO, 16'hAAAA);
    rw(`ADR_CAP_LO, 16'h0444);
    cpu.wr8(`ADR_CTRL_B, 8'h58);
    cpu.wr16(`ADR_CAP_LO, 16'h4321);
    rw(`ADR_CAP_LO, 16'h4321);
    comparator_output <= 1'b0;
    wirq(1'b0);
    comparator_output <= 1'b1;
    wirq(1'b0);
    rw(`ADR_CAP_LO, 16'h4321);
    cpu.wr8(`ADR_CTRL_B, 8'hC0);
    comparator_output <= 1'b0;
    wirq(1'b0);
    comparator_output <= 1'b1;
    repeat (2) @(posedge mclk);
    comparator_output <= 1'b0;
    wirq(1'b0);
    comparator_output <= 1'b1;
    wirq(1'b1);
    rw(`ADR_CAP_LO, 16'h0444);
    end_sim;
  end
endmodule // test_timer16_counter_capture_access
